/* File: core/sat_add_sub_alu.sv */
// registered saturating add/sub datapath with sticky saturation flag
`timescale 1ns/1ps
`default_nettype none
module sat_add_sub_alu
  import sat_alu_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // issue from decode
  input  wire logic        issue,
  input  wire sat_op_t     op,
  input  wire logic [3:0]  op_pattern,
  input  wire logic [3:0]  dest_reg_field,
  input  wire logic [3:0]  operand_a_reg_field,
  input  wire logic [3:0]  operand_b_reg_field,
  input  wire logic [31:0] operand_a,
  input  wire logic [31:0] operand_b,
  // writeback
  output logic             wr_en,
  output logic      [3:0]  wr_reg,
  output logic      [31:0] wr_data,
  output logic             application_status_reg_q
);

  // lane saturators use one helper per lane width: sat16 for halfwords, sat8 for bytes
  function automatic logic [15:0] sat16(input logic [16:0] v);
    if (v[16] == v[15]) return v[15:0];
    return v[16] ? 16'h8000 : 16'h7fff;
  endfunction

  function automatic logic [7:0] sat8(input logic [8:0] v);
    if (v[8] == v[7]) return v[7:0];
    return v[8] ? 8'h80 : 8'h7f;
  endfunction

  function automatic logic bad_reg(input logic [3:0] r);
    return (r == REG_STACK) || (r == REG_PC);
  endfunction

  // operand a is the first operand, operand b the second
  logic [31:0] dbl_res;
  logic        dbl_sat;
  logic [31:0] main_rhs;
  logic        main_sub;
  logic [31:0] main_res;
  logic        main_sat;
  logic [31:0] quad_res;
  logic [31:0] dual_res;
  logic [31:0] exch_res;
  logic        is_word_add;
  logic        is_double;
  logic        illegal;

  // the word add is recognised by its pattern as well as the op code
  assign is_word_add = (op == OP_ADD_WORD) && (op_pattern == PAT_WORD_ADD);
  assign is_double   = (op == OP_DOUBLE_ADD) || (op == OP_DOUBLE_SUB);
  // the decoder must not hand us these; we refuse the write rather than corrupt state
  assign illegal = bad_reg(dest_reg_field) || bad_reg(operand_a_reg_field)
                 || bad_reg(operand_b_reg_field);

  sat_word_unit u_double (
    .lhs    (operand_b),
    .rhs    (operand_b),
    .do_sub (1'b0),
    .res    (dbl_res),
    .sat    (dbl_sat)
  );

  always_comb begin
    main_rhs = is_double ? dbl_res : operand_b;
    main_sub = (op == OP_DOUBLE_SUB);
  end

  sat_word_unit u_main (
    .lhs    (operand_a),
    .rhs    (main_rhs),
    .do_sub (main_sub),
    .res    (main_res),
    .sat    (main_sat)
  );

  genvar g;
  generate
    for (g = 0; g < LANES_B; g++) begin : g_byte
      // lanes are sliced independently so no carry crosses them
      assign quad_res[g*8 +: 8] = sat8({operand_a[g*8+7], operand_a[g*8 +: 8]}
                                     + {operand_b[g*8+7], operand_b[g*8 +: 8]});
    end
    for (g = 0; g < 2; g++) begin : g_half
      assign dual_res[g*16 +: 16] = sat16({operand_a[g*16+15], operand_a[g*16 +: 16]}
                                       + {operand_b[g*16+15], operand_b[g*16 +: 16]});
    end
  endgenerate

  // second operand halves swapped
  assign exch_res[15:0]  = sat16({operand_a[15], operand_a[15:0]}
                              - {operand_b[31], operand_b[31:16]});
  assign exch_res[31:16] = sat16({operand_a[31], operand_a[31:16]}
                              + {operand_b[15], operand_b[15:0]});

  logic        wr_en_nxt;
  logic [3:0]  wr_reg_nxt;
  logic [31:0] wr_data_nxt;
  logic        q_nxt;

  always_comb begin
    wr_en_nxt   = 1'b0;
    wr_reg_nxt  = wr_reg;
    wr_data_nxt = wr_data;
    q_nxt       = application_status_reg_q;
    if (issue && !illegal) begin
      case (op)
        OP_ADD_WORD: begin
          if (is_word_add) begin
            wr_en_nxt   = 1'b1;
            wr_data_nxt = main_res;
            q_nxt       = application_status_reg_q | main_sat;
          end
        end
        OP_ADD_DUAL_HALF: begin
          wr_en_nxt   = 1'b1;
          wr_data_nxt = dual_res;
        end
        OP_ADD_QUAD_BYTE: begin
          wr_en_nxt   = 1'b1;
          wr_data_nxt = quad_res;
        end
        OP_EXCH_ADD_SUB: begin
          wr_en_nxt   = 1'b1;
          wr_data_nxt = exch_res;
        end
        OP_DOUBLE_ADD, OP_DOUBLE_SUB: begin
          wr_en_nxt   = 1'b1;
          wr_data_nxt = main_res;
          q_nxt = application_status_reg_q | dbl_sat | main_sat;
        end
        default: begin
          wr_en_nxt = 1'b0;
        end
      endcase
      // a refused issue leaves the last destination on show
      if (wr_en_nxt) begin
        wr_reg_nxt = dest_reg_field;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wr_en                    <= 1'b0;
      wr_reg                   <= 4'h0;
      wr_data                  <= RESULT_RST;
      application_status_reg_q <= STICKY_RST;
    end else begin
      wr_en                    <= wr_en_nxt;
      wr_reg                   <= wr_reg_nxt;
      wr_data                  <= wr_data_nxt;
      application_status_reg_q <= q_nxt;
    end
  end

  sequence s_dbl_issue;
    issue && !illegal && is_double;
  endsequence

  sequence s_dbl_clamp;
    dbl_sat && !main_sat;
  endsequence

  a_sticky_never_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
    application_status_reg_q |=> application_status_reg_q)
    else $error("sticky flag cleared");

  a_word_add_value: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && is_word_add |=> wr_en && wr_data == $past(main_res))
    else $error("word add result wrong");

  // checked against the operands themselves, not the adder's own output
  a_word_add_sum: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && is_word_add && !main_sat
    |=> wr_data == $past(operand_a) + $past(operand_b))
    else $error("word add sum wrong");

  a_pattern_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && op == OP_ADD_WORD && op_pattern != PAT_WORD_ADD |=> !wr_en)
    else $error("word add taken without its pattern");

  a_word_add_sets_q: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && is_word_add && main_sat |=> application_status_reg_q)
    else $error("word add clamp did not set flag");

  a_double_step_q: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_dbl_issue and s_dbl_clamp |=> application_status_reg_q)
    else $error("doubling clamp did not set flag");

  a_double_sub_q: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && op == OP_DOUBLE_SUB && main_sat |=> application_status_reg_q)
    else $error("double sub clamp did not set flag");

  a_double_sub_value: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && op == OP_DOUBLE_SUB && !dbl_sat && !main_sat
    |=> wr_data == $past(operand_a) - ($past(operand_b) << 1))
    else $error("double sub result wrong");

  a_lane_q_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && (op == OP_ADD_QUAD_BYTE || op == OP_ADD_DUAL_HALF || op == OP_EXCH_ADD_SUB)
    |=> application_status_reg_q == $past(application_status_reg_q))
    else $error("lane op changed flag");

  a_quad_lane_pass: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && op == OP_ADD_QUAD_BYTE && operand_b == 32'h0
    |=> wr_data == $past(operand_a))
    else $error("byte lanes misaligned");

  a_dual_clamp_hi: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && op == OP_ADD_DUAL_HALF
    && operand_a[31:16] == 16'h7fff && !operand_b[31]
    |=> wr_data[31:16] == 16'h7fff)
    else $error("half lane not clamped");

  a_byte_clamp_lo: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && op == OP_ADD_QUAD_BYTE
    && operand_a[7:0] == 8'h80 && operand_b[7]
    |=> wr_data[7:0] == 8'h80)
    else $error("byte lane not clamped");

  a_exch_lanes: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && op == OP_EXCH_ADD_SUB && operand_b == 32'h0001_0000
    && operand_a == 32'h0000_0005 |=> wr_data == 32'h0000_0004)
    else $error("exchange lanes wrong");

  a_double_add_value: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && !illegal && op == OP_DOUBLE_ADD && operand_b == 32'h4000_0000
    && operand_a == 32'h8000_0000 |=> wr_data == 32'hffff_ffff)
    else $error("double add result wrong");

  a_bad_reg_no_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    issue && illegal |=> !wr_en)
    else $error("write with reserved register");
endmodule
`default_nettype wire

/* File: common/sat_alu_pkg.sv */
// constants and types for the saturating add/sub datapath
package sat_alu_pkg;

  localparam int unsigned WORD_W  = 32;
  localparam int unsigned HALF_W  = 16;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned REG_N_W = 4;
  localparam int unsigned LANES_B = 4;

  // register numbers that the decoder must never present
  localparam logic [3:0] REG_STACK = 4'hd;
  localparam logic [3:0] REG_PC    = 4'hf;

  // operation pattern field of the second halfword
  localparam logic [3:0] PAT_WORD_ADD = 4'h8;

  // reset values
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic        STICKY_RST = 1'b0;

  typedef enum logic [2:0] {
    OP_NONE          = 3'b000,
    OP_ADD_WORD      = 3'b001,
    OP_ADD_DUAL_HALF = 3'b010,
    OP_ADD_QUAD_BYTE = 3'b011,
    OP_EXCH_ADD_SUB  = 3'b100,
    OP_DOUBLE_ADD    = 3'b101,
    OP_DOUBLE_SUB    = 3'b110
  } sat_op_t;

endpackage

/* File: core/sat_word_unit.sv */
// one signed 32-bit saturating add or subtract with a saturation flag
`timescale 1ns/1ps
`default_nettype none
module sat_word_unit
  import sat_alu_pkg::*;
(
  // operands
  input  wire logic [31:0] lhs,
  input  wire logic [31:0] rhs,
  input  wire logic        do_sub,
  // answer
  output logic      [31:0] res,
  output logic             sat
);
  logic [32:0] wide;

  always_comb begin
    if (do_sub) begin
      wide = {lhs[31], lhs} - {rhs[31], rhs};
    end else begin
      wide = {lhs[31], lhs} + {rhs[31], rhs};
    end
    sat = wide[32] ^ wide[31];
    if (!sat) begin
      res = wide[31:0];
    end else if (wide[32]) begin
      res = 32'h8000_0000;
    end else begin
      res = 32'h7fff_ffff;
    end
  end
endmodule
`default_nettype wire

/* File: sim/sat_decode_model.sv */
// decoder and register-file side model that presents instructions to the datapath
`timescale 1ns/1ps
`default_nettype none
module sat_decode_model
  import sat_alu_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // issue toward the datapath
  output logic             issue,
  output sat_op_t          op,
  output logic      [3:0]  op_pattern,
  output logic      [3:0]  dest_reg_field,
  output logic      [3:0]  operand_a_reg_field,
  output logic      [3:0]  operand_b_reg_field,
  output logic      [31:0] operand_a,
  output logic      [31:0] operand_b
);
  initial begin
    issue = 1'b0;
    op = OP_NONE;
    op_pattern = 4'h0;
    dest_reg_field = 4'h0;
    operand_a_reg_field = 4'h0;
    operand_b_reg_field = 4'h0;
    operand_a = 32'h0;
    operand_b = 32'h0;
  end

  // register numbers 13 and 15 appear only when a caller asks for them
  task automatic send(input sat_op_t o, input logic [3:0] pat, rd, ra, rb,
                      input logic [31:0] a, b);
    @(posedge sys_clk);
    issue <= 1'b1;
    op <= o;
    op_pattern <= pat;
    dest_reg_field <= rd;
    operand_a_reg_field <= ra;
    operand_b_reg_field <= rb;
    operand_a <= a;
    operand_b <= b;
    @(posedge sys_clk);
    issue <= 1'b0;
    // stale operands are inverted so a late sample cannot pass by luck
    operand_a <= ~a;
    operand_b <= ~b;
  endtask
endmodule
`default_nettype wire

/* File: sim/saturating_add_sub_alu_test.sv */
// self-checking bench for the saturating add/sub datapath
`timescale 1ns/1ps
`default_nettype none
module saturating_add_sub_alu_test
  import sat_alu_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic issue;
  sat_op_t op;
  logic [3:0] op_pattern;
  logic [3:0] dest_reg_field;
  logic [3:0] operand_a_reg_field;
  logic [3:0] operand_b_reg_field;
  logic [31:0] operand_a;
  logic [31:0] operand_b;
  logic wr_en;
  logic [3:0] wr_reg;
  logic [31:0] wr_data;
  logic application_status_reg_q;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  logic [3:0] dst = 4'h1;

  always #12.5 sys_clk = ~sys_clk;

  sat_decode_model sat_decode_model_i (.sys_clk(sys_clk), .issue(issue), .op(op),
    .op_pattern(op_pattern), .dest_reg_field(dest_reg_field),
    .operand_a_reg_field(operand_a_reg_field), .operand_b_reg_field(operand_b_reg_field),
    .operand_a(operand_a), .operand_b(operand_b));

  sat_add_sub_alu sat_add_sub_alu_i (.sys_clk(sys_clk), .nrst(nrst), .issue(issue), .op(op),
    .op_pattern(op_pattern), .dest_reg_field(dest_reg_field),
    .operand_a_reg_field(operand_a_reg_field), .operand_b_reg_field(operand_b_reg_field),
    .operand_a(operand_a), .operand_b(operand_b), .wr_en(wr_en), .wr_reg(wr_reg),
    .wr_data(wr_data), .application_status_reg_q(application_status_reg_q));

  task automatic chk_data(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one accepted instruction; the writeback is registered on the taking edge and checked 1 ns after it
  task automatic run(sat_op_t o, logic [3:0] pat, logic [31:0] a, b, e, logic fl);
    dst = (dst > 4'hb) ? 4'h1 : dst + 4'h1;
    sat_decode_model_i.send(o, pat, dst, 4'h2, 4'h4, a, b);
    #1;
    chk_bit("wr_en", 1'b1, wr_en);
    chk_data("wr_reg", {28'h0, dst}, {28'h0, wr_reg});
    chk_data("wr_data", e, wr_data);
    chk_bit("sticky flag", fl, application_status_reg_q);
  endtask

  // operands would saturate a word add, so any write would also raise the flag
  task automatic refuse(sat_op_t o, logic [3:0] pat, rd, ra, rb);
    sat_decode_model_i.send(o, pat, rd, ra, rb, 32'h7fff_ffff, 32'h7fff_ffff);
    #1;
    chk_bit("no write", 1'b0, wr_en);
    chk_bit("flag kept", 1'b0, application_status_reg_q);
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk_bit("flag after reset", 1'b0, application_status_reg_q);
    chk_data("data after reset", 32'h0, wr_data);
  endtask

  task automatic t_lanes();
    run(OP_ADD_DUAL_HALF, 4'h0, 32'h7000_8000, 32'h7000_8000, 32'h7fff_8000, 1'b0);
    run(OP_ADD_DUAL_HALF, 4'h0, 32'h1234_fff0, 32'h0001_0005, 32'h1235_fff5, 1'b0);
    run(OP_ADD_QUAD_BYTE, 4'h0, 32'h7f80_0102, 32'h0180_ff7f, 32'h7f80_007f, 1'b0);
    run(OP_ADD_QUAD_BYTE, 4'h0, 32'h00ff_ff10, 32'h0001_0120, 32'h0000_0030, 1'b0);
    run(OP_EXCH_ADD_SUB, 4'h0, 32'h7fff_8000, 32'h0001_0001, 32'h7fff_8000, 1'b0);
    run(OP_EXCH_ADD_SUB, 4'h0, 32'h0010_0020, 32'h0003_0005, 32'h0015_001d, 1'b0);
    run(OP_EXCH_ADD_SUB, 4'h0, 32'h0000_0005, 32'h0001_0000, 32'h0000_0004, 1'b0);
    run(OP_ADD_DUAL_HALF, 4'h0, 32'h7fff_0001, 32'h0001_ffff, 32'h7fff_0000, 1'b0);
    run(OP_ADD_QUAD_BYTE, 4'h0, 32'h80ff_7f01, 32'h0000_0000, 32'h80ff_7f01, 1'b0);
    run(OP_ADD_QUAD_BYTE, 4'h0, 32'h0102_0380, 32'h0101_0181, 32'h0203_0480, 1'b0);
    $display("lane forms done");
  endtask

  task automatic t_refuse();
    refuse(OP_ADD_WORD, 4'h8, 4'hd, 4'h2, 4'h4);
    refuse(OP_ADD_WORD, 4'h8, 4'h1, 4'hf, 4'h4);
    refuse(OP_ADD_WORD, 4'h8, 4'h1, 4'h2, 4'hd);
    refuse(OP_ADD_WORD, 4'h0, 4'h1, 4'h2, 4'h4);
    refuse(OP_NONE, 4'h8, 4'h1, 4'h2, 4'h4);
    $display("refusals done");
  endtask

  task automatic t_word();
    run(OP_ADD_WORD, 4'h8, 32'h0000_0005, 32'hffff_fffe, 32'h0000_0003, 1'b0);
    run(OP_ADD_WORD, 4'h8, 32'h7fff_ffff, 32'h0000_0001, 32'h7fff_ffff, 1'b1);
    run(OP_ADD_WORD, 4'h8, 32'h8000_0000, 32'hffff_ffff, 32'h8000_0000, 1'b1);
    run(OP_ADD_DUAL_HALF, 4'h0, 32'h0001_0001, 32'h0001_0001, 32'h0002_0002, 1'b1);
    $display("word add done");
  endtask

  task automatic t_double();
    do_reset();
    run(OP_DOUBLE_ADD, 4'h0, 32'h0000_0010, 32'h0000_0003, 32'h0000_0016, 1'b0);
    run(OP_DOUBLE_ADD, 4'h0, 32'h8000_0000, 32'h4000_0000, 32'hffff_ffff, 1'b1);
    do_reset();
    run(OP_DOUBLE_SUB, 4'h0, 32'h0000_0010, 32'h0000_0003, 32'h0000_000a, 1'b0);
    run(OP_DOUBLE_SUB, 4'h0, 32'hffff_fffd, 32'hbfff_ffff, 32'h7fff_fffd, 1'b1);
    // only the subtraction clamps here, so the flag comes from the second step
    do_reset();
    run(OP_DOUBLE_SUB, 4'h0, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000, 1'b1);
    $display("doubling forms done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // the whole sequence needs well under 200 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_lanes();
    t_refuse();
    t_word();
    t_double();
    print_verdict();
  end
endmodule
`default_nettype wire
